// *** core/mdu_arith.sv ***
// Combinational arithmetic of the multiply/divide unit.
// Assumes latched operands and the current result registers as inputs.
`timescale 1ns/1ps
`default_nettype none
module mdu_arith
  import mdu_pkg::*;
(
  input wire mdu_op_t op,
  input wire logic uns,
  input wire logic dbl,
  input wire logic [XLEN-1:0] a,
  input wire logic [XLEN-1:0] b,
  input wire logic [XLEN-1:0] upper_in,
  input wire logic [XLEN-1:0] bottom_in,
  output var mdu_res_t res,
  output var logic [XLEN-1:0] word_product
);

  function automatic logic [XLEN-1:0] sext_word(input logic [WORD-1:0] w);
    return {{(XLEN-WORD){w[WORD-1]}}, w};
  endfunction

  logic [XLEN-1:0] opa;
  logic [XLEN-1:0] opb;
  logic signed [XLEN:0] xa;
  logic signed [XLEN:0] xb;
  logic signed [2*XLEN+1:0] prod;
  logic signed [XLEN:0] quo;
  logic signed [XLEN:0] rem;
  logic [XLEN-1:0] acc;
  logic [XLEN-1:0] acc_n;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // Word ops look only at the low word and re-extend it
    if (dbl) begin
      opa = a;
      opb = b;
    end else if (uns) begin
      opa = {{(XLEN-WORD){1'b0}}, a[WORD-1:0]}; // RULE_04
      opb = {{(XLEN-WORD){1'b0}}, b[WORD-1:0]};
    end else begin
      opa = sext_word(a[WORD-1:0]); // RULE_04
      opb = sext_word(b[WORD-1:0]);
    end
    // One extra bit lets a single signed datapath serve both variants
    xa = {~uns & opa[XLEN-1], opa}; // RULE_17
    xb = {~uns & opb[XLEN-1], opb}; // RULE_17
    prod = xa * xb; // RULE_01 RULE_03
    // Zero divisor gives all-ones quotient, dividend as remainder
    if (opb == '0) begin
      quo = '1;
      rem = xa;
    end else begin
      quo = xa / xb;
      rem = xa % xb;
    end
    acc = {upper_in[WORD-1:0], bottom_in[WORD-1:0]};
    if (op == MDU_MULTIPLY_SUBTRACT) begin
      acc_n = acc - prod[XLEN-1:0]; // RULE_15
    end else begin
      acc_n = acc + prod[XLEN-1:0]; // RULE_13
    end
    word_product = sext_word(prod[WORD-1:0]); // RULE_14
    res.upper = upper_in;
    res.bottom = bottom_in;
    case (op)
      MDU_MULT: begin
        if (dbl) begin
          res.upper = prod[2*XLEN-1:XLEN]; // RULE_03
          res.bottom = prod[XLEN-1:0];
        end else begin
          res.upper = sext_word(prod[2*WORD-1:WORD]); // RULE_01
          res.bottom = sext_word(prod[WORD-1:0]);
        end
      end
      MDU_DIV: begin
        if (dbl) begin
          res.upper = rem[XLEN-1:0]; // RULE_06
          res.bottom = quo[XLEN-1:0];
        end else begin
          res.upper = sext_word(rem[WORD-1:0]); // RULE_06
          res.bottom = sext_word(quo[WORD-1:0]);
        end
      end
      MDU_MADD, MDU_MULTIPLY_SUBTRACT: begin
        res.upper = sext_word(acc_n[2*WORD-1:WORD]); // RULE_13 RULE_15
        res.bottom = sext_word(acc_n[WORD-1:0]);
      end
      default: begin
        res.upper = upper_in;
        res.bottom = bottom_in;
      end
    endcase
  end

endmodule
`default_nettype wire

// *** core/mdu_core.sv ***
// Multiply/divide unit with private upper and bottom result registers.
// Assumes the integer pipeline issues ops, reads and writes as one-cycle
// requests synchronous to ref_clk and honours the stall output.
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE_01: Two 32-bit operands multiply into a 64-bit product held across upper and bottom.
// RULE_02: Reads copy the upper or bottom result register out to a general register.
// RULE_03: In the 64-bit build two 64-bit operands give a 128-bit product across both.
// RULE_04: In the 64-bit build the issuer supplies word operands properly sign-extended.
// RULE_05: A read issued while an op runs stalls the pipeline and returns the final result.
// RULE_06: A divide leaves the quotient in bottom and the remainder in upper.
// RULE_07: In the 32-bit build a multiply takes 12 cycles and a divide 35.
// RULE_08: In the 64-bit build word multiply takes 10, doubleword 12, divides 42 and 74.
// RULE_09: Result registers update the moment a result is ready, not at writeback.
// RULE_10: A cancelled read is dropped while a running op goes on and may overwrite both.
// RULE_11: Software should not start a multiply within two instructions of a read.
// RULE_12: Writes load upper or bottom from a general register, for state restore.
// RULE_13: Multiply-accumulate adds the product to the 64-bit upper:bottom accumulator.
// RULE_14: The three-operand multiply hands its product straight to a general register.
// RULE_15: Multiply-subtract subtracts the product from the same accumulator.
// RULE_16: A running op never holds up other instructions, only result reads.
// RULE_17: Signed ops use two's complement, unsigned plain binary; a new op replaces one running.
module mdu_core
  import mdu_pkg::*;
#(
  parameter bit WIDE = 1'b1,
  parameter bit HAS_MADD = 1'b1,
  parameter bit HAS_MULTIPLY_SUBTRACT = 1'b1,
  parameter bit HAS_MUL3 = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire mdu_req_t req,
  input wire mdu_rd_t rd_req,
  input wire logic rd_cancel,
  input wire mdu_wr_t wr,
  output logic rd_ack,
  output logic [XLEN-1:0] rd_data,
  output logic stall,
  output logic busy,
  output logic gpr_valid,
  output logic [XLEN-1:0] gpr_data
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    mdu_state_t state;
    logic [CNT_W-1:0] cnt;
    mdu_op_t op;
    logic uns;
    logic dbl;
    logic [XLEN-1:0] a;
    logic [XLEN-1:0] b;
    logic [XLEN-1:0] upper;
    logic [XLEN-1:0] bottom;
    logic rd_pend;
    mdu_sel_t rd_sel;
    logic rd_ack;
    logic [XLEN-1:0] rd_data;
    logic stall;
    logic gpr_valid;
    logic [XLEN-1:0] gpr_data;
  } mdu_core_st_t;

  mdu_core_st_t s_q;
  mdu_core_st_t s_d;
  mdu_res_t res;
  logic [XLEN-1:0] word_product;
  logic done;
  logic start;
  logic rd_pend;
  mdu_sel_t rd_sel;
  logic dbl_eff;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [CNT_W-1:0] op_lat(input mdu_op_t op, input logic dbl);
    logic [CNT_W-1:0] lat;
    if (op == MDU_DIV) begin
      if (!WIDE) begin
        lat = LAT32_DIV; // RULE_07
      end else if (dbl) begin
        lat = LAT64_DDIV; // RULE_08
      end else begin
        lat = LAT64_DIV; // RULE_08
      end
    end else if (!WIDE) begin
      lat = LAT32_MUL; // RULE_07
    end else if (dbl) begin
      lat = LAT64_MUL + LAT64_DMUL_EXTRA; // RULE_08
    end else begin
      lat = LAT64_MUL; // RULE_08
    end
    return lat;
  endfunction

  function automatic logic op_ok(input mdu_op_t op, input logic dbl);
    logic ok;
    case (op)
      MDU_MULT, MDU_DIV: ok = 1'b1;
      MDU_MADD: ok = HAS_MADD && !dbl;
      MDU_MULTIPLY_SUBTRACT: ok = HAS_MULTIPLY_SUBTRACT && !dbl;
      MDU_MUL3: ok = HAS_MUL3 && !dbl;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic [XLEN-1:0] pick(input mdu_sel_t sel,
                                           input logic [XLEN-1:0] up,
                                           input logic [XLEN-1:0] bot);
    return (sel == MDU_SEL_UPPER) ? up : bot;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic on latched operands
  // Accumulate ops read upper:bottom at completion, so a restore write that
  // lands while they run is folded in
  mdu_arith u_arith (
    .op(s_q.op),
    .uns(s_q.uns),
    .dbl(s_q.dbl),
    .a(s_q.a),
    .b(s_q.b),
    .upper_in(s_q.upper),
    .bottom_in(s_q.bottom),
    .res(res),
    .word_product(word_product)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.rd_ack = 1'b0;
    s_d.gpr_valid = 1'b0;
    // Doubleword forms only exist in the wide build
    dbl_eff = WIDE && req.dbl;
    done = (s_q.state == MDU_BUSY) && (s_q.cnt == '0);
    start = req.valid && op_ok(req.op, dbl_eff);

    // Completion writes straight into the result registers, or for MDU_MUL3 into gpr_data
    if (done) begin
      s_d.state = MDU_IDLE;
      if (s_q.op == MDU_MUL3) begin
        s_d.gpr_valid = 1'b1; // RULE_14
        s_d.gpr_data = word_product;
      end else if (!start) begin
        // A start in the finishing cycle aborts the old op, so it writes nothing
        s_d.upper = res.upper; // RULE_09
        s_d.bottom = res.bottom; // RULE_09
      end
    end

    // Restore writes win over a result landing in the same cycle
    if (wr.valid) begin
      if (wr.sel == MDU_SEL_UPPER) begin
        s_d.upper = wr.data; // RULE_12
      end else begin
        s_d.bottom = wr.data; // RULE_12
      end
    end

    // A new op discards whatever was running, finished or not
    if (start) begin
      s_d.state = MDU_BUSY; // RULE_17
      s_d.cnt = op_lat(req.op, dbl_eff) - CNT_ONE;
      s_d.op = req.op;
      s_d.uns = req.uns;
      s_d.dbl = dbl_eff;
      s_d.a = req.a;
      s_d.b = req.b;
      s_d.gpr_valid = 1'b0;
    end else if (s_q.state == MDU_BUSY && !done) begin
      s_d.cnt = s_q.cnt - CNT_ONE;
    end

    // Reads wait only for the unit, nothing else in the pipe does
    rd_pend = rd_req.valid ? 1'b1 : s_q.rd_pend; // RULE_16
    rd_sel = rd_req.valid ? rd_req.sel : s_q.rd_sel;
    if (rd_cancel) begin
      rd_pend = 1'b0; // RULE_10
    end
    if (rd_pend && s_q.state == MDU_IDLE) begin
      s_d.rd_ack = 1'b1; // RULE_02
      s_d.rd_data = pick(rd_sel, s_q.upper, s_q.bottom); // RULE_02
      s_d.rd_pend = 1'b0;
    end else begin
      s_d.rd_pend = rd_pend; // RULE_05
    end
    s_d.rd_sel = rd_sel;
    s_d.stall = s_d.rd_pend; // RULE_05
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rd_ack = s_q.rd_ack;
  assign rd_data = s_q.rd_data;
  assign stall = s_q.stall;
  assign busy = (s_q.state == MDU_BUSY);
  assign gpr_valid = s_q.gpr_valid;
  assign gpr_data = s_q.gpr_data;

endmodule
`default_nettype wire

// *** core/mdu_pkg.sv ***
// Shared types and constants of the multiply/divide unit.
// Assumes a single clock domain and an integer pipeline that issues the ops.
package mdu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int unsigned XLEN = 64;
  localparam int unsigned WORD = 32;
  localparam int unsigned CNT_W = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Latencies in clock cycles
  localparam logic [CNT_W-1:0] LAT32_MUL = 7'h0c;   // 12
  localparam logic [CNT_W-1:0] LAT32_DIV = 7'h23;   // 35
  localparam logic [CNT_W-1:0] LAT64_MUL = 7'h0a;   // 10
  localparam logic [CNT_W-1:0] LAT64_DMUL_EXTRA = 7'h02;
  localparam logic [CNT_W-1:0] LAT64_DIV = 7'h2a;   // 42
  localparam logic [CNT_W-1:0] LAT64_DDIV = 7'h4a;  // 74
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Operations, selectors, states
  typedef enum logic [2:0] {
    MDU_MULT,
    MDU_DIV,
    MDU_MADD,
    MDU_MULTIPLY_SUBTRACT,
    MDU_MUL3
  } mdu_op_t;

  typedef enum logic {
    MDU_SEL_BOTTOM,
    MDU_SEL_UPPER
  } mdu_sel_t;

  typedef enum logic {
    MDU_IDLE,
    MDU_BUSY
  } mdu_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic valid;
    mdu_op_t op;
    logic uns;
    logic dbl;
    logic [XLEN-1:0] a;
    logic [XLEN-1:0] b;
  } mdu_req_t;

  typedef struct packed {
    logic valid;
    mdu_sel_t sel;
  } mdu_rd_t;

  typedef struct packed {
    logic valid;
    mdu_sel_t sel;
    logic [XLEN-1:0] data;
  } mdu_wr_t;

  typedef struct packed {
    logic [XLEN-1:0] upper;
    logic [XLEN-1:0] bottom;
  } mdu_res_t;

endpackage

// *** test/mdu_core_asserts.sv ***
// Port assertions for the multiply/divide unit.
// Assumes binding to mdu_core; one clock, async reset.
`timescale 1ns/1ps
`default_nettype none
module mdu_core_asserts
  import mdu_pkg::*;
#(
  parameter bit WIDE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire mdu_req_t req,
  input wire mdu_rd_t rd_req,
  input wire logic rd_cancel,
  input wire logic rd_ack,
  input wire logic stall,
  input wire logic busy,
  input wire logic gpr_valid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic ed;
  logic take;
  logic [CNT_W-1:0] lat;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] lat_q;
  assign ed = req.dbl && WIDE;
  // Doubleword accumulate forms are not taken
  assign take = req.valid && (req.op == MDU_MULT || req.op == MDU_DIV || !ed);
  assign lat = (req.op == MDU_DIV) ? (WIDE ? (ed ? LAT64_DDIV : LAT64_DIV) : LAT32_DIV)
    : (WIDE ? (ed ? LAT64_MUL + LAT64_DMUL_EXTRA : LAT64_MUL) : LAT32_MUL);
  // Counter restarts on every take, so a replaced op is timed afresh
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      lat_q <= '0;
    end else if (take) begin
      cnt_q <= CNT_ONE;
      lat_q <= lat;
    end else if (busy) begin
      cnt_q <= cnt_q + CNT_ONE;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_rd_busy;
    rd_req.valid && !rd_cancel && busy ##1 busy;
  endsequence
  a_op_latency: assert property ($fell(busy) |-> cnt_q == lat_q + CNT_ONE)
    else $error("op latency wrong");
  a_op_starts: assert property (take |=> busy)
    else $error("op not started");
  a_idle_ack: assert property (rd_req.valid && !rd_cancel && !busy |=> rd_ack)
    else $error("idle read not acked");
  a_busy_stall: assert property (s_rd_busy |-> stall)
    else $error("busy read did not stall");
  a_stall_hold: assert property (stall && busy && !rd_cancel |=> stall && !rd_ack)
    else $error("stall dropped early");
  a_stall_ack: assert property ($fell(busy) && stall && !rd_cancel && !take |=> rd_ack && !stall)
    else $error("stalled read not answered");
  a_cancel_drop: assert property (stall && rd_cancel |=> !stall && !rd_ack)
    else $error("cancelled read answered");
  a_gpr_done: assert property (gpr_valid |-> $fell(busy))
    else $error("gpr result out of step");
endmodule
bind mdu_core mdu_core_asserts #(.WIDE(WIDE)) u_asserts (.ref_clk(ref_clk), .rst(rst),
  .req(req), .rd_req(rd_req), .rd_cancel(rd_cancel), .rd_ack(rd_ack), .stall(stall),
  .busy(busy), .gpr_valid(gpr_valid));
`default_nettype wire

// *** test/mdu_wb_model.sv ***
// Pipeline writeback side: counts read answers, keeps last gpr result.
// Assumes the same clock and reset as the unit.
`timescale 1ns/1ps
`default_nettype none
module mdu_wb_model
  import mdu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic rd_ack,
  input wire logic gpr_valid,
  input wire logic [XLEN-1:0] gpr_data,
  output logic [15:0] ack_cnt,
  output logic [XLEN-1:0] wb_data
);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_cnt <= 16'h0000;
      wb_data <= '0;
    end else begin
      if (rd_ack) ack_cnt <= ack_cnt + 16'h0001;
      if (gpr_valid) wb_data <= gpr_data;
    end
  end
endmodule
`default_nettype wire

// *** test/multiply_divide_unit_tb.sv ***
// Self-checking bench for the multiply/divide unit.
// Assumes default build: 64-bit, all optional ops present.
`timescale 1ns/1ps
`default_nettype none
module multiply_divide_unit_tb;
  import mdu_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  mdu_req_t req = '0;
  mdu_rd_t rd_req = '0;
  logic rd_cancel = 1'b0;
  mdu_wr_t wr = '0;
  logic rd_ack, stall, busy, gpr_valid;
  logic [XLEN-1:0] rd_data, gpr_data, wb_data, d;
  logic [15:0] ack_cnt, n;
  int err_count = 0;
  int tests_run = 0;
`define CHK(g, e) begin if ((g) !== (e)) begin \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); err_count++; end tests_run++; end
  always #4 ref_clk = ~ref_clk;
  mdu_core uut (.ref_clk(ref_clk), .rst(rst), .req(req), .rd_req(rd_req),
    .rd_cancel(rd_cancel), .wr(wr), .rd_ack(rd_ack), .rd_data(rd_data), .stall(stall),
    .busy(busy), .gpr_valid(gpr_valid), .gpr_data(gpr_data));
  mdu_wb_model u_wb (.ref_clk(ref_clk), .rst(rst), .rd_ack(rd_ack), .gpr_valid(gpr_valid),
    .gpr_data(gpr_data), .ack_cnt(ack_cnt), .wb_data(wb_data));
  ////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Gap of two cycles keeps a start clear of a just-finished read
  task start(input mdu_op_t op, input logic u, input logic dl, input logic [XLEN-1:0] a,
    input logic [XLEN-1:0] b);
    repeat (2) @(posedge ref_clk);
    req <= '{1'b1, op, u, dl, a, b};
    @(posedge ref_clk);
    req.valid <= 1'b0;
  endtask
  task wait_idle;
    int i;
    i = 0;
    #1;
    while (busy !== 1'b0 && i < 200) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    if (i >= 200) begin err_count++; summarize(); end
  endtask
  task rd(input mdu_sel_t s, output logic [XLEN-1:0] v);
    int i;
    i = 0;
    @(posedge ref_clk);
    rd_req <= '{1'b1, s};
    @(posedge ref_clk);
    rd_req.valid <= 1'b0;
    #1;
    while (rd_ack !== 1'b1 && i < 200) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    if (i >= 200) begin err_count++; summarize(); end
    v = rd_data;
  endtask
  task wr_reg(input mdu_sel_t s, input logic [XLEN-1:0] v);
    @(posedge ref_clk);
    wr <= '{1'b1, s, v};
    @(posedge ref_clk);
    wr.valid <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_mul; // Sign-extended word operands, read while running
    start(MDU_MULT, 1'b0, 1'b0, 64'hffff_ffff_ffff_fffd, 64'h5);
    rd(MDU_SEL_BOTTOM, d); `CHK(d, 64'hffff_ffff_ffff_fff1)
    rd(MDU_SEL_UPPER, d); `CHK(d, 64'hffff_ffff_ffff_ffff)
    $display("t_mul done");
  endtask
  task t_dmul;
    start(MDU_MULT, 1'b1, 1'b1, 64'hffff_ffff_ffff_ffff, 64'h2);
    wait_idle();
    rd(MDU_SEL_UPPER, d); `CHK(d, 64'h1)
    rd(MDU_SEL_BOTTOM, d); `CHK(d, 64'hffff_ffff_ffff_fffe)
    $display("t_dmul done");
  endtask
  task t_div;
    start(MDU_DIV, 1'b0, 1'b0, 64'hffff_ffff_ffff_fff9, 64'h2);
    rd(MDU_SEL_BOTTOM, d); `CHK(d, 64'hffff_ffff_ffff_fffd)
    rd(MDU_SEL_UPPER, d); `CHK(d, 64'hffff_ffff_ffff_ffff)
    // Zero divisor: all-ones quotient, dividend left as remainder
    start(MDU_DIV, 1'b0, 1'b0, 64'h5, 64'h0);
    rd(MDU_SEL_UPPER, d); `CHK(d, 64'h5)
    rd(MDU_SEL_BOTTOM, d); `CHK(d, 64'hffff_ffff_ffff_ffff)
    $display("t_div done");
  endtask
  task t_acc;
    wr_reg(MDU_SEL_UPPER, 64'h0);
    wr_reg(MDU_SEL_BOTTOM, 64'h5);
    rd(MDU_SEL_BOTTOM, d); `CHK(d, 64'h5)
    start(MDU_MADD, 1'b0, 1'b0, 64'h3, 64'h4);
    rd(MDU_SEL_BOTTOM, d); `CHK(d, 64'h11)
    start(MDU_MULTIPLY_SUBTRACT, 1'b1, 1'b0, 64'h2, 64'h3);
    rd(MDU_SEL_BOTTOM, d); `CHK(d, 64'hb)
    rd(MDU_SEL_UPPER, d); `CHK(d, 64'h0)
    $display("t_acc done");
  endtask
  task t_mul3;
    start(MDU_MUL3, 1'b0, 1'b0, 64'h6, 64'h7);
    wait_idle();
    @(posedge ref_clk);
    #1;
    `CHK(wb_data, 64'h2a)
    $display("t_mul3 done");
  endtask
  task t_cancel; // Read dropped mid-divide, divide still completes
    start(MDU_DIV, 1'b1, 1'b1, 64'h64, 64'h7);
    n = ack_cnt;
    @(posedge ref_clk);
    rd_req <= '{1'b1, MDU_SEL_UPPER};
    @(posedge ref_clk);
    rd_req.valid <= 1'b0;
    rd_cancel <= 1'b1;
    #1;
    `CHK(stall, 1'b1)
    @(posedge ref_clk);
    rd_cancel <= 1'b0;
    #1;
    `CHK(stall, 1'b0)
    wait_idle();
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(ack_cnt, n)
    rd(MDU_SEL_UPPER, d); `CHK(d, 64'h2)
    rd(MDU_SEL_BOTTOM, d); `CHK(d, 64'he)
    $display("t_cancel done");
  endtask
  task t_replace;
    @(posedge ref_clk);
    req <= '{1'b1, MDU_DIV, 1'b0, 1'b0, 64'h64, 64'h7};
    @(posedge ref_clk);
    req <= '{1'b1, MDU_MULT, 1'b0, 1'b0, 64'h6, 64'h7};
    @(posedge ref_clk);
    req.valid <= 1'b0;
    wait_idle();
    rd(MDU_SEL_BOTTOM, d); `CHK(d, 64'h2a)
    rd(MDU_SEL_UPPER, d); `CHK(d, 64'h0)
    $display("t_replace done");
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_mul();
    t_dmul();
    t_div();
    t_acc();
    t_mul3();
    t_cancel();
    t_replace();
    summarize();
  end
endmodule
`default_nettype wire
